// ==== srb_receiver.sv ====
// Serial receive path: oversampling, synchronous and biphase receivers,
// character assembly, holding register and status flags.
// Assumes ovs_tick_i pulses once per oversampling period and that all
// inputs are synchronous to ref_clk_i.
//
// Chosen here: the address map and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none

module srb_receiver (
	input  wire logic        ref_clk_i,
	input  wire logic        rst_b_i,
	input  wire logic [4:0]  addr_i,
	input  wire logic [31:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	input  wire logic        rxd_i,
	input  wire logic        ovs_tick_i,
	input  wire logic        baud_clk_i,
	output logic      [31:0] rdata_o,
	output logic             rx_ready_o
);
	import srb_pkg::*;

	// Drift-adjusted period from tick position within the period
	function automatic logic [4:0] srb_drift(input logic [4:0] pos,
	                                         input logic [4:0] nom);
		logic [4:0] mid;
		mid = {1'b0, nom[4:1]};
		srb_drift = nom;
		if (pos < mid && (mid - pos) >= 5'h02 && (mid - pos) <= 5'h04)
			srb_drift = nom - 5'h01;
		else if (pos > mid && (pos - mid) >= 5'h02 && (pos - mid) <= 5'h03)
			srb_drift = nom + 5'h01;
	endfunction

	// Expected check bit for a character
	function automatic logic srb_want(input logic [2:0] t,
	                                  input logic [8:0] d);
		unique case (t)
			SRB_CHK_EVEN: srb_want = ^d;
			SRB_CHK_ODD:  srb_want = ~^d;
			SRB_CHK_MARK: srb_want = 1'b1;
			default:      srb_want = 1'b0;
		endcase
	endfunction

	srb_mode_t   mode;
	srb_bpcfg_t  bpcfg;
	srb_astate_t a_st;
	srb_sstate_t s_st;
	srb_bstate_t b_st;
	srb_cstate_t c_st;
	logic        rx_en;
	logic        dis_pend;
	logic        rx_q;
	logic        baud_q;
	logic [3:0]  a_low;
	logic [4:0]  a_ph;
	logic [4:0]  a_len;
	logic        a_start;
	logic        a_bv;
	logic        a_bit;
	logic        s_start;
	logic        s_bv;
	logic        s_bit;
	logic        b_start;
	logic        b_bv;
	logic        b_bit;
	logic        b_viol;
	logic        b_kind;
	logic        pre_bit;
	logic        hunt_hi;
	logic [2:0]  b_low;
	logic [4:0]  b_tk;
	logic [4:0]  b_len;
	logic [5:0]  hs;
	logic [2:0]  hn;
	logic [3:0]  cells;
	logic [3:0]  c_cnt;
	logic [8:0]  sh;
	logic [8:0]  next_sh;
	logic        char_done;
	logic        fin;
	logic        chk_ev;
	logic        frm_ev;
	logic [8:0]  hold_data;
	logic        hold_kind;
	logic        ovr;
	logic        chk_err;
	logic        frm_err;
	logic        bp_err;
	logic [31:0] stat_w;
	logic [31:0] hold_w;

	// Register port decode
	wire       wr_ctrl  = wr_i && addr_i == SRB_OFS_CTRL;
	wire       cmd_rst  = wr_ctrl && wdata_i[SRB_CMD_RX_RESET];
	wire       cmd_en   = wr_ctrl && wdata_i[SRB_CMD_RX_ENABLE];
	wire       cmd_dis  = wr_ctrl && wdata_i[SRB_CMD_RX_DISABLE];
	wire       cmd_clr  = wr_ctrl && wdata_i[SRB_CMD_STAT_CLEAR];
	wire       hold_rd  = rd_i && addr_i == SRB_OFS_HOLD;
	wire       halt     = !rx_en || cmd_rst;
	wire       drift_ok = bpcfg.drift_en && !mode.over_sel;
	wire       rx_edge  = rxd_i != rx_q;
	wire       rx_pol   = rxd_i ^ bpcfg.receive_line_polarity;
	wire       async_on = !mode.sync_sel && !mode.biphase_enable;
	wire       sync_on  = mode.sync_sel && !mode.biphase_enable;
	wire [4:0] nom      = mode.over_sel ? SRB_OVS8 : SRB_OVS16;
	wire [4:0] half     = {1'b0, nom[4:1]};
	wire [2:0] qtr      = nom[4:2];
	wire       all_idle = a_st == SRB_A_IDLE && s_st == SRB_S_IDLE
	                      && b_st == SRB_B_HUNT;

	// Configuration registers survive the receiver reset command
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			mode  <= SRB_MODE_RST;
			bpcfg <= SRB_BPCFG_RST;
		end else if (wr_i) begin
			if (addr_i == SRB_OFS_MODE)
				mode <= wdata_i[12:0];
			if (addr_i == SRB_OFS_BPCFG)
				bpcfg <= wdata_i[7:0];
		end
	end

	// Enable state; disable waits for the current character
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rx_en    <= 1'b0;
			dis_pend <= 1'b0;
		end else if (cmd_en) begin
			rx_en    <= 1'b1;
			dis_pend <= 1'b0;
		end else if (cmd_dis) begin
			dis_pend <= 1'b1;
		end else if (dis_pend && all_idle) begin
			rx_en    <= 1'b0;
			dis_pend <= 1'b0;
		end
	end

	// Previous line sample and baud clock level
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rx_q   <= 1'b1;
			baud_q <= 1'b0;
		end else begin
			baud_q <= baud_clk_i;
			if (ovs_tick_i)
				rx_q <= rxd_i;
		end
	end

	// Oversampling receiver
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			a_st    <= SRB_A_IDLE;
			a_low   <= 4'h0;
			a_ph    <= 5'h00;
			a_len   <= SRB_OVS16;
			a_start <= 1'b0;
			a_bv    <= 1'b0;
			a_bit   <= 1'b1;
		end else begin
			a_start <= 1'b0;
			a_bv    <= 1'b0;
			if (halt || !async_on || char_done) begin
				a_st  <= SRB_A_IDLE;
				a_low <= 4'h0;
			end else if (ovs_tick_i) begin
				unique case (a_st)
					SRB_A_IDLE: begin
						if (rxd_i) begin
							a_low <= 4'h0;
						end else if (a_low == half[3:0] - 4'h1) begin
							a_st    <= SRB_A_BITS;
							a_low   <= 4'h0;
							a_ph    <= 5'h00;
							a_len   <= nom;
							a_start <= 1'b1;
						end else begin
							a_low <= a_low + 4'h1;
						end
					end
					SRB_A_BITS: begin
						if (a_ph == a_len - 5'h01) begin
							a_ph  <= 5'h00;
							a_len <= nom;
							a_bv  <= 1'b1;
							a_bit <= rxd_i;
						end else begin
							a_ph <= a_ph + 5'h01;
							if (rx_edge && drift_ok)
								a_len <= srb_drift(a_ph + 5'h01, nom);
						end
					end
				endcase
			end
		end
	end

	// Synchronous receiver on baud clock rising edges
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s_st    <= SRB_S_IDLE;
			s_start <= 1'b0;
			s_bv    <= 1'b0;
			s_bit   <= 1'b1;
		end else begin
			s_start <= 1'b0;
			s_bv    <= 1'b0;
			if (halt || !sync_on || char_done) begin
				s_st <= SRB_S_IDLE;
			end else if (baud_clk_i && !baud_q) begin
				unique case (s_st)
					SRB_S_IDLE: begin
						if (!rxd_i) begin
							s_st    <= SRB_S_BITS;
							s_start <= 1'b1;
						end
					end
					SRB_S_BITS: begin
						s_bv  <= 1'b1;
						s_bit <= rxd_i;
					end
				endcase
			end
		end
	end

	// Biphase decoder: start, preamble, delimiter and data cells
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			b_st    <= SRB_B_HUNT;
			hunt_hi <= 1'b1;
			b_low   <= 3'h0;
			b_tk    <= 5'h00;
			b_len   <= 5'h08;
			hs      <= 6'h00;
			hn      <= 3'h0;
			cells   <= 4'h0;
			b_start <= 1'b0;
			b_bv    <= 1'b0;
			b_bit   <= 1'b0;
			b_viol  <= 1'b0;
			b_kind  <= 1'b0;
		end else begin
			b_start <= 1'b0;
			b_bv    <= 1'b0;
			b_viol  <= 1'b0;
			if (halt || !mode.biphase_enable || char_done) begin
				b_st    <= SRB_B_HUNT;
				hunt_hi <= 1'b0;
				b_low   <= 3'h0;
			end else if (ovs_tick_i && b_st == SRB_B_HUNT) begin
				if (rx_pol) begin
					hunt_hi <= 1'b1;
					b_low   <= 3'h0;
				end else if (hunt_hi && b_low == qtr - 3'h1) begin
					// Quarter point of the first cell reached
					b_st    <= (bpcfg.receive_preamble_length != 4'h0)
					           ? SRB_B_PRE : SRB_B_DELIM;
					hunt_hi <= 1'b0;
					b_low   <= 3'h0;
					hs      <= 6'h00;
					hn      <= 3'h1;
					cells   <= 4'h0;
					b_tk    <= 5'h00;
					b_len   <= half;
				end else if (hunt_hi) begin
					b_low <= b_low + 3'h1;
				end
			end else if (ovs_tick_i) begin
				if (b_tk == b_len - 5'h01) begin
					b_tk  <= 5'h00;
					b_len <= half;
					hs    <= {hs[4:0], rx_pol};
					hn    <= hn + 3'h1;
					unique case (b_st)
						SRB_B_PRE: begin
							if (hn[0]) begin
								if ({hs[0], rx_pol} != {pre_bit, !pre_bit}) begin
									b_st <= SRB_B_HUNT;
								end else if (cells ==
								     bpcfg.receive_preamble_length - 4'h1) begin
									b_st <= SRB_B_DELIM;
									hn   <= 3'h0;
								end
								cells <= cells + 4'h1;
							end
						end
						SRB_B_DELIM: begin
							if (mode.single_bit_delimiter) begin
								if (hn[0] && {hs[0], rx_pol} == 2'b01) begin
									b_st    <= SRB_B_DATA;
									b_start <= 1'b1;
									hn      <= 3'h0;
								end else if (hn[0]) begin
									b_st <= SRB_B_HUNT;
								end
							end else if (hn == 3'h5) begin
								if ({hs[4:0], rx_pol} == SRB_SYNC_CMD ||
								    {hs[4:0], rx_pol} == SRB_SYNC_DATA) begin
									b_st    <= SRB_B_DATA;
									b_start <= 1'b1;
									b_kind  <= hs[4];
									hn      <= 3'h0;
								end else begin
									b_st <= SRB_B_HUNT;
								end
							end
						end
						SRB_B_DATA: begin
							if (hn[0]) begin
								b_bv   <= 1'b1;
								b_bit  <= hs[0];
								b_viol <= hs[0] == rx_pol;
							end
						end
						default: b_st <= SRB_B_HUNT;
					endcase
				end else begin
					b_tk <= b_tk + 5'h01;
					if (rx_edge && drift_ok)
						b_len <= srb_drift(b_tk + 5'h01, half);
				end
			end
		end
	end

	// Expected preamble level of the current cell
	always_comb begin
		unique case (bpcfg.receive_preamble_pattern)
			SRB_PP_ONES:     pre_bit = 1'b1;
			SRB_PP_ZEROS:    pre_bit = 1'b0;
			SRB_PP_ONE_ZERO: pre_bit = !cells[0];
			SRB_PP_ZERO_ONE: pre_bit = cells[0];
		endcase
	end

	// Character assembly shared by all receivers
	wire       bv     = a_bv | s_bv | b_bv;
	wire       bval   = async_on ? a_bit : (sync_on ? s_bit : b_bit);
	wire       c_go   = a_start | s_start | b_start;
	wire       chk_on = mode.check_bit_type[2:1] != 2'b10;
	wire [3:0] nbits  = mode.nine_bit_select ? 4'h9
	                    : 4'h5 + {2'b00, mode.char_length};

	always_comb begin
		next_sh = sh;
		fin     = 1'b0;
		chk_ev  = 1'b0;
		frm_ev  = 1'b0;
		if (bv && !halt) begin
			unique case (c_st)
				SRB_C_DATA: begin
					if (mode.high_bit_first)
						next_sh = {sh[7:0], bval};
					else
						next_sh[c_cnt] = bval;
					fin = c_cnt == nbits - 4'h1 && !chk_on
					      && mode.biphase_enable;
				end
				SRB_C_CHK: begin
					chk_ev = bval != srb_want(mode.check_bit_type, sh);
					fin    = mode.biphase_enable;
				end
				SRB_C_STOP: begin
					frm_ev = !bval;
					fin    = 1'b1;
				end
				default: fin = 1'b0;
			endcase
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			c_st      <= SRB_C_DATA;
			c_cnt     <= 4'h0;
			sh        <= 9'h000;
			char_done <= 1'b0;
		end else begin
			char_done <= fin;
			sh        <= next_sh;
			if (halt || c_go) begin
				c_st  <= SRB_C_DATA;
				c_cnt <= 4'h0;
				sh    <= 9'h000;
			end else if (bv && c_st == SRB_C_DATA) begin
				c_cnt <= c_cnt + 4'h1;
				if (c_cnt == nbits - 4'h1)
					c_st <= chk_on ? SRB_C_CHK : SRB_C_STOP;
			end else if (bv && c_st == SRB_C_CHK) begin
				c_st <= SRB_C_STOP;
			end
		end
	end

	// Holding register and status flags; events win over clears
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			hold_data  <= 9'h000;
			hold_kind  <= 1'b0;
			rx_ready_o <= 1'b0;
			ovr        <= 1'b0;
			chk_err    <= 1'b0;
			frm_err    <= 1'b0;
			bp_err     <= 1'b0;
		end else if (cmd_rst) begin
			rx_ready_o <= 1'b0;
			ovr        <= 1'b0;
			chk_err    <= 1'b0;
			frm_err    <= 1'b0;
			bp_err     <= 1'b0;
		end else begin
			if (fin) begin
				hold_data <= next_sh;
				hold_kind <= mode.biphase_enable
				             && !mode.single_bit_delimiter && b_kind;
			end
			if (fin)
				rx_ready_o <= 1'b1;
			else if (hold_rd)
				rx_ready_o <= 1'b0;
			if (fin && rx_ready_o && !hold_rd)
				ovr <= 1'b1;
			else if (cmd_clr)
				ovr <= 1'b0;
			if (chk_ev)
				chk_err <= 1'b1;
			else if (cmd_clr)
				chk_err <= 1'b0;
			if (frm_ev)
				frm_err <= 1'b1;
			else if (cmd_clr)
				frm_err <= 1'b0;
			if (b_viol)
				bp_err <= 1'b1;
			else if (cmd_clr)
				bp_err <= 1'b0;
		end
	end

	// Read words
	always_comb begin
		stat_w                 = 32'h0000_0000;
		stat_w[SRB_ST_READY]   = rx_ready_o;
		stat_w[SRB_ST_OVERRUN] = ovr;
		stat_w[SRB_ST_FRAME]   = frm_err;
		stat_w[SRB_ST_CHECK]   = chk_err;
		stat_w[SRB_ST_BIPHASE] = bp_err;
		hold_w                 = {23'h000000, hold_data};
		hold_w[SRB_HOLD_KIND_BIT] = hold_kind;
	end

	// Read data one cycle after the strobe, zero elsewhere
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rdata_o <= 32'h0000_0000;
		end else if (rd_i) begin
			unique case (addr_i)
				SRB_OFS_MODE:  rdata_o <= {19'h00000, mode};
				SRB_OFS_BPCFG: rdata_o <= {24'h000000, bpcfg};
				SRB_OFS_STAT:  rdata_o <= stat_w;
				SRB_OFS_HOLD:  rdata_o <= hold_w;
				default:       rdata_o <= 32'h0000_0000;
			endcase
		end else begin
			rdata_o <= 32'h0000_0000;
		end
	end

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_b_i);

	wire a_run = async_on && !halt && !char_done && ovs_tick_i && a_st == SRB_A_BITS
	             && a_ph != a_len - 5'h01 && rx_edge && drift_ok;

	a_start_16x: assert property ($rose(a_st == SRB_A_BITS) && !mode.over_sel
		|-> $past(a_low) == 4'h7 && a_len == 5'h10)
		else $error("start at 16x not on eighth low sample");
	a_start_8x: assert property ($rose(a_st == SRB_A_BITS) && mode.over_sel
		|-> $past(a_low) == 4'h3 && a_len == 5'h08)
		else $error("start at 8x not on fourth low sample");
	a_no_drift_8x: assert property (a_st == SRB_A_BITS && mode.over_sel
		|-> a_len == 5'h08)
		else $error("bit period changed at 8x");
	a_drift_early: assert property (a_run && a_ph inside {5'h03, 5'h04, 5'h05}
		|=> a_len == 5'h0F)
		else $error("early edge did not shorten period");
	a_drift_late: assert property (a_run && a_ph inside {5'h09, 5'h0A}
		|=> a_len == 5'h11)
		else $error("late edge did not lengthen period");
	a_drift_jitter: assert property (a_run && a_ph inside {5'h06, 5'h07, 5'h08}
		|=> $stable(a_len))
		else $error("jitter edge changed period");
	a_ready_set: assert property (fin && !cmd_rst |=> rx_ready_o
		&& hold_data == $past(next_sh))
		else $error("finished character not held");
	a_overrun_set: assert property (fin && rx_ready_o && !hold_rd && !cmd_rst
		|=> ovr)
		else $error("overrun not flagged");
	a_read_clears: assert property (hold_rd && !fin && !cmd_rst |=> !rx_ready_o)
		else $error("holding read left ready set");
	a_biphase_sticky: assert property (bp_err && !cmd_clr && !cmd_rst |=> bp_err)
		else $error("biphase error dropped without clear");
	a_reset_cmd: assert property (cmd_rst |=> !rx_ready_o && !ovr && !bp_err
		&& all_idle && $stable(mode))
		else $error("receiver reset incomplete");
	a_stop_rehunt: assert property (char_done |=> a_st == SRB_A_IDLE)
		else $error("no start search after stop");
	a_disabled_idle: assert property (!rx_en [*2] |-> all_idle)
		else $error("reception while disabled");

endmodule
`default_nettype wire

// ==== srb_pkg.sv ====
// Shared constants, field layouts and state codes of the serial receive path.
// Assumes a plain register port with byte offsets on a 5-bit address.
package srb_pkg;

	// Register byte offsets
	localparam logic [4:0] SRB_OFS_CTRL  = 5'h00;
	localparam logic [4:0] SRB_OFS_MODE  = 5'h04;
	localparam logic [4:0] SRB_OFS_BPCFG = 5'h08;
	localparam logic [4:0] SRB_OFS_STAT  = 5'h0C;
	localparam logic [4:0] SRB_OFS_HOLD  = 5'h10;

	// Command bits of the control register
	localparam int SRB_CMD_RX_RESET   = 2;
	localparam int SRB_CMD_RX_ENABLE  = 4;
	localparam int SRB_CMD_RX_DISABLE = 5;
	localparam int SRB_CMD_STAT_CLEAR = 8;

	// Status bit positions
	localparam int SRB_ST_READY   = 0;
	localparam int SRB_ST_OVERRUN = 5;
	localparam int SRB_ST_FRAME   = 6;
	localparam int SRB_ST_CHECK   = 7;
	localparam int SRB_ST_BIPHASE = 8;

	// Holding register fields
	localparam int SRB_HOLD_KIND_BIT = 15;

	// Reset values
	localparam logic [12:0] SRB_MODE_RST  = 13'h0000;
	localparam logic [7:0]  SRB_BPCFG_RST = 8'h00;

	// Oversampling counts per bit and per biphase cell, at 16x and 8x
	localparam logic [4:0] SRB_OVS16 = 5'h10;
	localparam logic [4:0] SRB_OVS8  = 5'h08;

	// Check bit types
	localparam logic [2:0] SRB_CHK_EVEN  = 3'h0;
	localparam logic [2:0] SRB_CHK_ODD   = 3'h1;
	localparam logic [2:0] SRB_CHK_SPACE = 3'h2;
	localparam logic [2:0] SRB_CHK_MARK  = 3'h3;

	// Preamble patterns
	localparam logic [1:0] SRB_PP_ONES     = 2'h0;
	localparam logic [1:0] SRB_PP_ZEROS    = 2'h1;
	localparam logic [1:0] SRB_PP_ONE_ZERO = 2'h2;
	localparam logic [1:0] SRB_PP_ZERO_ONE = 2'h3;

	// Sync delimiters as six half-cell samples
	localparam logic [5:0] SRB_SYNC_CMD  = 6'h38;
	localparam logic [5:0] SRB_SYNC_DATA = 6'h07;

	typedef struct packed {
		logic       single_bit_delimiter;
		logic       biphase_enable;
		logic       over_sel;
		logic       high_bit_first;
		logic       nine_bit_select;
		logic [1:0] stop_count;
		logic [2:0] check_bit_type;
		logic       sync_sel;
		logic [1:0] char_length;
	} srb_mode_t;

	typedef struct packed {
		logic       drift_en;
		logic       receive_line_polarity;
		logic [1:0] receive_preamble_pattern;
		logic [3:0] receive_preamble_length;
	} srb_bpcfg_t;

	typedef enum logic {SRB_A_IDLE = 1'b0, SRB_A_BITS = 1'b1} srb_astate_t;
	typedef enum logic {SRB_S_IDLE = 1'b0, SRB_S_BITS = 1'b1} srb_sstate_t;
	typedef enum logic [1:0] {
		SRB_B_HUNT  = 2'b00,
		SRB_B_PRE   = 2'b01,
		SRB_B_DELIM = 2'b10,
		SRB_B_DATA  = 2'b11
	} srb_bstate_t;
	typedef enum logic [1:0] {
		SRB_C_DATA = 2'b00,
		SRB_C_CHK  = 2'b01,
		SRB_C_STOP = 2'b10
	} srb_cstate_t;

endpackage

// ==== srb_line_model.sv ====
// Far-side serial sender that drives the receive line symbol by symbol.
// Assumes the bench calls send and that ovs_tick_i is one cycle wide.
`timescale 1ns/10ps
`default_nettype none
module srb_line_model (
	input  wire logic ref_clk_i,
	input  wire logic ovs_tick_i,
	output logic      rxd_o
);
	// Line rests high between frames, like a pulled-up idle line
	initial rxd_o = 1'b1;

	// Sends n symbols, lowest first, each held for t oversampling ticks
	task automatic send(input logic [31:0] bits, input int n, input int t);
		for (int i = 0; i < n; i++) begin
			rxd_o <= bits[i];
			repeat (t) @(posedge ref_clk_i iff ovs_tick_i);
		end
		rxd_o <= 1'b1;
	endtask
endmodule
`default_nettype wire

// ==== srb_receiver_bench.sv ====
// Self-checking bench of the serial receive path.
// Assumes the line model as far side and a tick every fourth clock.
`timescale 1ns/10ps
`default_nettype none
module srb_receiver_bench;
	import srb_pkg::*;
	logic        ref_clk_i  = 1'b0;
	logic        rst_b_i    = 1'b0;
	logic [4:0]  addr_i     = 5'h00;
	logic [31:0] wdata_i    = 32'h0;
	logic        wr_i       = 1'b0;
	logic        rd_i       = 1'b0;
	logic        ovs_tick_i = 1'b0;
	logic        baud_clk_i = 1'b0;
	logic [1:0]  tick_cnt   = 2'h0;
	logic [3:0]  tick16     = 4'h0;
	logic        rxd_i;
	logic [31:0] rdata_o;
	logic        rx_ready_o;
	int          n_mismatch = 0;
	int          n_compared = 0;

	srb_receiver dut_u (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rxd_i(rxd_i),
		.ovs_tick_i(ovs_tick_i), .baud_clk_i(baud_clk_i), .rdata_o(rdata_o),
		.rx_ready_o(rx_ready_o));
	srb_line_model tx_u (.ref_clk_i(ref_clk_i), .ovs_tick_i(ovs_tick_i), .rxd_o(rxd_i));

	// Clock, oversampling tick and a baud clock of sixteen ticks
	always #10 ref_clk_i = ~ref_clk_i;
	always @(posedge ref_clk_i) begin
		tick_cnt <= tick_cnt + 2'h1;
		ovs_tick_i <= (tick_cnt == 2'h3);
		if (ovs_tick_i)
			tick16 <= tick16 + 4'h1;
		baud_clk_i <= tick16[3];
	end

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		@(posedge ref_clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge ref_clk_i);
		wr_i <= 1'b0;
	endtask

	// Read strobe for one cycle, data looked at in the following cycle
	task automatic rchk(input string nm, input logic [4:0] a, input logic [31:0] e);
		@(posedge ref_clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge ref_clk_i);
		rd_i <= 1'b0;
		@(negedge ref_clk_i);
		chk(nm, e, rdata_o);
	endtask

	task automatic wait_rdy();
		for (int i = 0; i < 2000 && rx_ready_o !== 1'b1; i++) @(posedge ref_clk_i);
		@(negedge ref_clk_i);
		chk("ready", 32'h1, {31'h0, rx_ready_o});
	endtask

	task automatic endt(input string nm);
		$display("test %s done", nm);
	endtask

	function automatic logic [31:0] frm(input logic [7:0] d);
		return {22'h0, 1'b1, d, 1'b0};
	endfunction

	// Prefix of np halves, then cells; bad picks a cell without mid transition
	function automatic logic [31:0] bp(input logic [7:0] d, input int bad,
	                                   input logic [31:0] pre, input int np);
		logic [31:0] s;
		s = pre;
		for (int i = 0; i < 8; i++) s[np + 2 * i +: 2] = (i == bad) ? {d[i], d[i]} : {~d[i], d[i]};
		return s;
	endfunction

	task automatic summarize();
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// Watchdog against a hang
	initial begin
		repeat (60000) @(posedge ref_clk_i);
		n_mismatch++;
		summarize();
	end

	// Test sequence
	initial begin
		repeat (5) @(posedge ref_clk_i);
		rst_b_i <= 1'b1;
		rchk("mode", SRB_OFS_MODE, 32'h0);
		rchk("bpcfg", SRB_OFS_BPCFG, 32'h0);
		rchk("unmapped", 5'h1C, 32'h0);
		endt("reset values");
		wr(SRB_OFS_MODE, 32'h23);
		rchk("mode", SRB_OFS_MODE, 32'h23);
		tx_u.send(frm(8'hA5), 10, 16);
		repeat (100) @(posedge ref_clk_i);
		rchk("stat", SRB_OFS_STAT, 32'h0);
		endt("disabled");
		wr(SRB_OFS_CTRL, 32'h1 << SRB_CMD_RX_ENABLE);
		tx_u.send(frm(8'hA5), 10, 16);
		wait_rdy();
		rchk("hold", SRB_OFS_HOLD, 32'hA5);
		chk("ready", 32'h0, {31'h0, rx_ready_o});
		endt("16x");
		tx_u.send({12'h0, 1'b1, 8'h66, 1'b0, 1'b1, 8'h99, 1'b0}, 20, 16);
		wait_rdy();
		rchk("stat", SRB_OFS_STAT, 32'h21);
		rchk("hold", SRB_OFS_HOLD, 32'h66);
		rchk("stat", SRB_OFS_STAT, 32'h20);
		wr(SRB_OFS_CTRL, 32'h1 << SRB_CMD_STAT_CLEAR);
		rchk("stat", SRB_OFS_STAT, 32'h0);
		endt("overrun");
		wr(SRB_OFS_MODE, 32'h423);
		tx_u.send(frm(8'h3C), 10, 8);
		wait_rdy();
		rchk("hold", SRB_OFS_HOLD, 32'h3C);
		endt("8x");
		wr(SRB_OFS_MODE, 32'h03);
		tx_u.send({21'h0, 1'b1, 1'b0, 8'h01, 1'b0}, 11, 16);
		wait_rdy();
		rchk("stat", SRB_OFS_STAT, 32'h81);
		rchk("hold", SRB_OFS_HOLD, 32'h01);
		wr(SRB_OFS_CTRL, 32'h1 << SRB_CMD_STAT_CLEAR);
		endt("check bit");
		// Senders one tick fast and one tick slow per bit
		wr(SRB_OFS_MODE, 32'h23);
		wr(SRB_OFS_BPCFG, 32'h80);
		tx_u.send(frm(8'h55), 10, 15);
		wait_rdy();
		rchk("hold", SRB_OFS_HOLD, 32'h55);
		tx_u.send(frm(8'h55), 10, 17);
		wait_rdy();
		rchk("hold", SRB_OFS_HOLD, 32'h55);
		wr(SRB_OFS_BPCFG, 32'h00);
		endt("drift");
		// Symbols start as the baud counter wraps, so rises fall mid-bit
		wr(SRB_OFS_MODE, 32'h227);
		@(posedge ref_clk_i iff (ovs_tick_i && tick16 == 4'hF));
		tx_u.send(frm(8'h1E), 10, 16);
		wait_rdy();
		rchk("hold", SRB_OFS_HOLD, 32'h78);
		endt("sync");
		wr(SRB_OFS_MODE, 32'h1823);
		repeat (8) @(posedge ref_clk_i);
		tx_u.send(bp(8'h5A, 9, 32'h2, 2), 18, 8);
		wait_rdy();
		rchk("hold", SRB_OFS_HOLD, 32'h5A);
		tx_u.send(bp(8'h5A, 3, 32'h2, 2), 18, 8);
		wait_rdy();
		rchk("stat", SRB_OFS_STAT, 32'h101);
		rchk("hold", SRB_OFS_HOLD, 32'h5A);
		rchk("stat", SRB_OFS_STAT, 32'h100);
		endt("biphase");
		// Two zero preamble cells, then a command sync
		wr(SRB_OFS_MODE, 32'h823);
		wr(SRB_OFS_BPCFG, 32'h12);
		tx_u.send(bp(8'hC3, 9, 32'h7A, 10), 26, 8);
		wait_rdy();
		rchk("hold", SRB_OFS_HOLD, 32'h80C3);
		wr(SRB_OFS_BPCFG, 32'h00);
		wr(SRB_OFS_MODE, 32'h1823);
		endt("sync delimiter");
		wr(SRB_OFS_CTRL, 32'h1 << SRB_CMD_RX_RESET);
		rchk("stat", SRB_OFS_STAT, 32'h0);
		rchk("mode", SRB_OFS_MODE, 32'h1823);
		endt("soft reset");
		wr(SRB_OFS_CTRL, 32'h1 << SRB_CMD_RX_DISABLE);
		tx_u.send(bp(8'h5A, 9, 32'h2, 2), 18, 8);
		rchk("stat", SRB_OFS_STAT, 32'h0);
		endt("disable");
		summarize();
	end
endmodule
`default_nettype wire
